/* rtl/classd_seq_pkg.sv */
// Package with constants, types and states of the class-D protection sequencer.
// Behaviour
// - Outputs stay Hi-Z until supplies are good.
// - Reset low enables weak output pulldowns.
// - Ramps last 100 ms plus 1 ms/nF.
// - Output PWM follows input PWM during ramps.
// - Fault: Hi-Z power stage, fault output low.
// - Non-latching faults recover by themselves.
// - Channel faults switch off groups by mode.
// - Bootstrap undervoltage turns off one high side.
// - Pin-short check runs only at logic power-up.
// - Found short holds Hi-Z until removed.
// - Check tests ground then output supply.
// - Check time scales with filter capacitance.
// - Check holds fault low, ignores reset.
// - No recheck on reset; skipped single-ended.
// - Thermal warning output low when hot.
// - Thermal shutdown latches, Hi-Z, fault low.
// - Thermal latch clears only on reset.
// - Reset low forces fault output high.
// - Fault and warning are active-low open-drain.
package classd_seq_pkg;

  // Clock rate and the millisecond tick.
  localparam int unsigned CLK_HZ  = 20_000_000;
  localparam int unsigned TICK_MS = 1;

  // Ramp base time and pin-short step time per microfarad of filter.
  localparam int unsigned RAMP_BASE_MS    = 100;
  localparam int unsigned STEP_MS_PER_UF  = 7;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // Control register fields and reset values.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CAP_LSB  = 8;
  localparam int unsigned CTRL_RAMP_LSB = 16;
  localparam logic [2:0]  MODE_RST      = 3'h1;
  localparam logic [7:0]  CAP_UF_RST    = 8'h01;
  localparam logic [15:0] RAMP_NF_RST   = 16'h0064;

  // Output configuration codes.
  localparam logic [2:0] MODE_PARALLEL = 3'h3;
  localparam logic [2:0] MODE_SINGLE   = 3'h5;

  // Status register field positions.
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_DONE_BIT  = 4;
  localparam int unsigned ST_TRIP_BIT  = 5;
  localparam int unsigned ST_OVL_LSB   = 6;
  localparam int unsigned ST_UV_BIT    = 10;
  localparam int unsigned ST_WARN_BIT  = 11;

  // Sequencer states.
  typedef enum logic [3:0] {
    st_supply_wait,
    st_short_gnd,
    st_short_sup,
    st_idle,
    st_ramp_up,
    st_run,
    st_ramp_down
  } seq_state_t;

  // Pin-level inputs, all asynchronous to pclk.
  typedef struct packed {
    logic       gate_drive_ok;
    logic       logic_ok;
    logic       output_supply_ok;
    logic       amp_reset_n;
    logic       temp_hot;
    logic       temp_trip;
    logic [3:0] overload;
    logic [3:0] bootstrap_uv;
    logic [3:0] short_gnd;
    logic [3:0] short_sup;
    logic [3:0] pwm_in;
  } pin_in_t;

  // Drives toward the four half-bridges.
  typedef struct packed {
    logic [3:0] hi_z;
    logic [3:0] high_side_en;
    logic [3:0] pulldown_en;
    logic [3:0] pwm_out;
  } bridge_out_t;

endpackage

/* rtl/sync_bank.sv */
// Two-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Asynchronous inputs and synchronised outputs.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // First stage feeds only the second; nothing else reads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_bank

/* rtl/classd_protection_sequencer.sv */
// Power-up, ramp, pin-short check and fault sequencer for a four half-bridge stage.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module classd_protection_sequencer #(
  parameter int unsigned MS_CYCLES = classd_seq_pkg::CLK_HZ / 1000 * classd_seq_pkg::TICK_MS
) (
  // Clock and reset.
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave.
  input  wire logic [7:0]                   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Pins from supplies, sensors, reset and modulator.
  input  wire classd_seq_pkg::pin_in_t      pins,
  // Half-bridge drives.
  output classd_seq_pkg::bridge_out_t       bridge,
  output logic      [16:0]                  ramp_ms,
  // Open-drain active-low fault and thermal warning.
  output logic                              fault_n_o,
  output logic                              fault_n_oe,
  output logic                              temp_warn_n_o,
  output logic                              temp_warn_n_oe
);

  classd_seq_pkg::pin_in_t    pin_s;
  classd_seq_pkg::seq_state_t state;
  classd_seq_pkg::seq_state_t next_state;

  logic [2:0]  mode;
  logic [7:0]  cap_uf;
  logic [15:0] ramp_nf;
  logic        check_done;
  logic        thermal_shutdown;
  logic [3:0]  overload_latch;
  logic [14:0] tick_cnt;
  logic [16:0] ms_count;
  logic        tick;
  logic        undervoltage;
  logic        rst_s;
  logic        single_ended;
  logic        parallel;
  logic        checking;
  logic [16:0] ramp_target;
  logic [16:0] step_target;
  logic        ramp_done;
  logic        step_done;
  logic [3:0]  group_off;
  logic [3:0]  next_hi_z;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;

  // All pin inputs pass two flops before any logic reads them.
  sync_bank #(
    .W($bits(classd_seq_pkg::pin_in_t))
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_in(pins),
    .sync_out(pin_s)
  );

  // Channel-to-group mapping: pairs in bridged and single-ended, all in parallel.
  function automatic logic [3:0] group_mask(input logic [3:0] flt, input logic par);
    logic [3:0] m;
    m = '0;
    if (par) begin
      m = {4{|flt}};
    end else begin
      m = {{2{|flt[3:2]}}, {2{|flt[1:0]}}};
    end
    return m;
  endfunction

  // Decoded conditions used across the sequencer.
  assign undervoltage = !(pin_s.gate_drive_ok && pin_s.logic_ok && pin_s.output_supply_ok);
  assign rst_s        = pin_s.amp_reset_n;
  assign single_ended = (mode == classd_seq_pkg::MODE_SINGLE);
  assign parallel     = (mode == classd_seq_pkg::MODE_PARALLEL);
  assign checking     = (state == classd_seq_pkg::st_short_gnd) || (state == classd_seq_pkg::st_short_sup);
  assign ramp_target  = 17'(classd_seq_pkg::RAMP_BASE_MS) + {1'b0, ramp_nf};
  assign step_target  = 17'(classd_seq_pkg::STEP_MS_PER_UF * 32'(cap_uf));
  assign ramp_done    = ms_count >= ramp_target;
  assign step_done    = ms_count >= step_target;
  assign group_off    = group_mask(overload_latch, parallel);
  assign tick         = (tick_cnt == 15'(MS_CYCLES - 1));

  // APB decode; the slave never inserts wait states.
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign addr_ok = (paddr == classd_seq_pkg::OFS_CTRL) || (paddr == classd_seq_pkg::OFS_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Control register: mode, filter capacitance in uF, ramp capacitance in nF.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode    <= classd_seq_pkg::MODE_RST;
      cap_uf  <= classd_seq_pkg::CAP_UF_RST;
      ramp_nf <= classd_seq_pkg::RAMP_NF_RST;
    end else if (wr_en && paddr == classd_seq_pkg::OFS_CTRL) begin
      mode    <= pwdata[classd_seq_pkg::CTRL_MODE_LSB +: 3];
      cap_uf  <= pwdata[classd_seq_pkg::CTRL_CAP_LSB +: 8];
      ramp_nf <= pwdata[classd_seq_pkg::CTRL_RAMP_LSB +: 16];
    end
  end

  // Read data is registered in the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en && !penable) begin
      prdata <= '0;
      if (paddr == classd_seq_pkg::OFS_CTRL) begin
        prdata <= {ramp_nf, cap_uf, 5'h00, mode};
      end else if (paddr == classd_seq_pkg::OFS_STATUS) begin
        prdata[classd_seq_pkg::ST_STATE_LSB +: 4] <= state;
        prdata[classd_seq_pkg::ST_DONE_BIT]       <= check_done;
        prdata[classd_seq_pkg::ST_TRIP_BIT]       <= thermal_shutdown;
        prdata[classd_seq_pkg::ST_OVL_LSB +: 4]   <= overload_latch;
        prdata[classd_seq_pkg::ST_UV_BIT]         <= undervoltage;
        prdata[classd_seq_pkg::ST_WARN_BIT]       <= pin_s.temp_hot;
      end
    end
  end

  // Millisecond tick and a per-state elapsed count that restarts on every state change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      ms_count <= '0;
    end else if (next_state != state) begin
      tick_cnt <= '0;
      ms_count <= '0;
    end else begin
      tick_cnt <= tick ? 15'h0000 : tick_cnt + 15'h0001;
      if (tick && ms_count != 17'h1ffff) begin
        ms_count <= ms_count + 17'h00001;
      end
    end
  end

  // Sequencer transitions; undervoltage overrides everything and is self clearing.
  always_comb begin
    next_state = state;
    unique case (state)
      classd_seq_pkg::st_supply_wait: begin
        if (!undervoltage) begin
          next_state = (!check_done && !single_ended) ? classd_seq_pkg::st_short_gnd
                                                      : classd_seq_pkg::st_idle;
        end
      end
      classd_seq_pkg::st_short_gnd: begin
        if (step_done && !(|pin_s.short_gnd)) begin
          next_state = classd_seq_pkg::st_short_sup;
        end
      end
      classd_seq_pkg::st_short_sup: begin
        if (step_done && !(|pin_s.short_sup)) begin
          next_state = classd_seq_pkg::st_idle;
        end
      end
      classd_seq_pkg::st_idle: begin
        if (rst_s && !thermal_shutdown) begin
          next_state = classd_seq_pkg::st_ramp_up;
        end
      end
      classd_seq_pkg::st_ramp_up: begin
        if (!rst_s) begin
          next_state = classd_seq_pkg::st_ramp_down;
        end else if (ramp_done) begin
          next_state = classd_seq_pkg::st_run;
        end
      end
      classd_seq_pkg::st_run: begin
        if (!rst_s) begin
          next_state = classd_seq_pkg::st_ramp_down;
        end
      end
      classd_seq_pkg::st_ramp_down: begin
        if (ramp_done) begin
          next_state = classd_seq_pkg::st_idle;
        end
      end
      default: next_state = classd_seq_pkg::st_supply_wait;
    endcase
    // A thermal trip drops the stage straight to idle; it needs a reset to leave.
    if (thermal_shutdown && !checking && state != classd_seq_pkg::st_supply_wait) begin
      next_state = classd_seq_pkg::st_idle;
    end
    if (undervoltage) begin
      next_state = classd_seq_pkg::st_supply_wait;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= classd_seq_pkg::st_supply_wait;
    end else begin
      state <= next_state;
    end
  end

  // The check is owed only once per logic-supply power-up; a pin reset never re-arms it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_done <= 1'b0;
    end else if (!pin_s.logic_ok) begin
      check_done <= 1'b0;
    end else if (state == classd_seq_pkg::st_short_sup && next_state == classd_seq_pkg::st_idle) begin
      check_done <= 1'b1;
    end
  end

  // Thermal and overload latches; a trip in the reset cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_shutdown <= 1'b0;
      overload_latch   <= '0;
    end else begin
      if (pin_s.temp_trip) begin
        thermal_shutdown <= 1'b1;
      end else if (!rst_s && !checking) begin
        thermal_shutdown <= 1'b0;
      end
      if (state == classd_seq_pkg::st_run || state == classd_seq_pkg::st_ramp_up) begin
        overload_latch <= overload_latch | pin_s.overload;
      end else if (!rst_s && !checking) begin
        overload_latch <= '0;
      end
    end
  end

  // Any half-bridge is Hi-Z unless ramping or running with no fault on its group.
  always_comb begin
    next_hi_z = 4'hf;
    if (!undervoltage && !thermal_shutdown &&
        (state == classd_seq_pkg::st_ramp_up || state == classd_seq_pkg::st_run ||
         state == classd_seq_pkg::st_ramp_down)) begin
      next_hi_z = group_off;
    end
  end

  // Bridge drives are registered; PWM follows the input while switching.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge  <= '{hi_z: 4'hf, high_side_en: 4'h0, pulldown_en: 4'h0, pwm_out: 4'h0};
      ramp_ms <= '0;
    end else begin
      bridge.hi_z         <= next_hi_z;
      bridge.high_side_en <= ~next_hi_z & ~pin_s.bootstrap_uv;
      bridge.pulldown_en  <= (!rst_s && !checking) ? next_hi_z : 4'h0;
      bridge.pwm_out      <= pin_s.pwm_in & ~next_hi_z;
      ramp_ms             <= (state == classd_seq_pkg::st_ramp_up ||
                              state == classd_seq_pkg::st_ramp_down) ? ms_count : 17'h00000;
    end
  end

  // Open-drain pins only ever pull low; the board pullup supplies the high level.
  assign fault_n_o     = 1'b0;
  assign temp_warn_n_o = 1'b0;

  // Fault reporting: check forces low, reset low forces high, else any fault pulls low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_n_oe     <= 1'b0;
      temp_warn_n_oe <= 1'b0;
    end else begin
      if (checking) begin
        fault_n_oe <= 1'b1;
      end else if (!rst_s) begin
        fault_n_oe <= 1'b0;
      end else begin
        fault_n_oe <= undervoltage || thermal_shutdown || (|overload_latch);
      end
      temp_warn_n_oe <= pin_s.temp_hot;
    end
  end

  // Undervoltage drives every bridge Hi-Z within two cycles.
  property p_uv_hiz;
    @(posedge pclk) disable iff (!presetn) undervoltage |-> ##[1:2] (bridge.hi_z == 4'hf);
  endproperty
  a_uv_hiz: assert property (p_uv_hiz) else $error("bridges not Hi-Z under undervoltage");

  property p_pulldown;
    @(posedge pclk) disable iff (!presetn)
      (state == classd_seq_pkg::st_idle && !rst_s) |=> (bridge.pulldown_en == 4'hf);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown missing while reset low");

  property p_ramp_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == classd_seq_pkg::st_run) |->
        (ramp_ms == 17'(classd_seq_pkg::RAMP_BASE_MS) + {1'b0, ramp_nf});
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("ramp ended early");

  property p_trip_hiz;
    @(posedge pclk) disable iff (!presetn)
      (thermal_shutdown && rst_s) |=> (bridge.hi_z == 4'hf) && fault_n_oe;
  endproperty
  a_trip_hiz: assert property (p_trip_hiz) else $error("thermal shutdown not reported");

  property p_group;
    @(posedge pclk) disable iff (!presetn)
      (overload_latch[0] && !parallel) |=> (bridge.hi_z[1:0] == 2'b11);
  endproperty
  a_group: assert property (p_group) else $error("group A+B not switched off");

  property p_boot;
    @(posedge pclk) disable iff (!presetn) pin_s.bootstrap_uv[0] |=> !bridge.high_side_en[0];
  endproperty
  a_boot: assert property (p_boot) else $error("high side on with bootstrap undervoltage");

  property p_check_entry;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == classd_seq_pkg::st_short_gnd) |-> !single_ended && !check_done &&
        ($past(state) == classd_seq_pkg::st_supply_wait);
  endproperty
  a_check_entry: assert property (p_check_entry) else $error("pin-short check started wrongly");

  property p_short_hold;
    @(posedge pclk) disable iff (!presetn)
      (state == classd_seq_pkg::st_short_sup && (|pin_s.short_sup) && !undervoltage)
        |=> state == classd_seq_pkg::st_short_sup;
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("check passed with short present");

  property p_check_fault;
    @(posedge pclk) disable iff (!presetn) checking |=> fault_n_oe;
  endproperty
  a_check_fault: assert property (p_check_fault) else $error("fault released during check");

  property p_reset_fault;
    @(posedge pclk) disable iff (!presetn) (!rst_s && !checking) |=> !fault_n_oe;
  endproperty
  a_reset_fault: assert property (p_reset_fault) else $error("fault low while reset held");

  property p_warn;
    @(posedge pclk) disable iff (!presetn) pin_s.temp_hot |=> temp_warn_n_oe;
  endproperty
  a_warn: assert property (p_warn) else $error("thermal warning not driven");

  // Main scenarios reached.
  c_run: cover property (@(posedge pclk) disable iff (!presetn) state == classd_seq_pkg::st_run);
  c_short: cover property (@(posedge pclk) disable iff (!presetn)
    state == classd_seq_pkg::st_short_gnd && (|pin_s.short_gnd));
  c_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(thermal_shutdown));
  c_down: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(state == classd_seq_pkg::st_ramp_down));

endmodule // classd_protection_sequencer

/* testbench/pwm_partner.sv */
// Behavioural PWM modulator that feeds idle PWM to the sequencer.
`timescale 1ns/1ps
module pwm_partner (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Channels held at ground because they are unused.
  input  wire logic [3:0] unused,
  // PWM toward the sequencer.
  output logic      [3:0] pwm
);
  // Muted 50% idle PWM runs whenever out of reset, so every ramp sees it; unused inputs stay grounded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm <= 4'h0;
    end else begin
      pwm <= ~pwm & ~unused;
    end
  end
endmodule // pwm_partner

/* testbench/classd_protection_sequencer_test.sv */
// Self-checking testbench of the class-D protection sequencer.
`timescale 1ns/1ps
module classd_protection_sequencer_test;
  // Bench-driven inputs.
  logic                        pclk    = 1'b0;
  logic                        presetn = 1'b0;
  logic [7:0]                  paddr   = 8'h00;
  logic                        psel    = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite  = 1'b0;
  logic [31:0]                 pwdata  = 32'h00000000;
  logic [3:0]                  unused  = 4'h0;
  classd_seq_pkg::pin_in_t     pn      = '0;
  // Design outputs and bench state.
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  classd_seq_pkg::bridge_out_t bridge;
  logic [16:0]                 ramp_ms;
  logic                        fault_n_o;
  logic                        fault_n_oe;
  logic                        temp_warn_n_o;
  logic                        temp_warn_n_oe;
  logic [3:0]                  pwm;
  logic [31:0]                 q;
  logic                        e;
  int                          fails   = 0;
  int                          n_tests = 0;
  int                          cyc     = 0;
  // Pin bundle carries the partner PWM; open-drain lines resolve against pull-ups.
  wire classd_seq_pkg::pin_in_t pins = {pn[25:4], pwm};
  wire fault_n = fault_n_oe ? fault_n_o : 1'b1;
  wire temp_warn_n = temp_warn_n_oe ? temp_warn_n_o : 1'b1;

  classd_protection_sequencer #(.MS_CYCLES(4)) u_classd_protection_sequencer (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .bridge(bridge),
    .ramp_ms(ramp_ms), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .temp_warn_n_o(temp_warn_n_o),
    .temp_warn_n_oe(temp_warn_n_oe));
  pwm_partner u_pwm_partner (.pclk(pclk), .presetn(presetn), .unused(unused), .pwm(pwm));

  // Free-running 20 MHz clock.
  always #25 pclk = ~pclk;

  // The run is far shorter than this ceiling, so reaching it means a hang.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Verdict and end of the run.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Value comparison.
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask

  // Cycle waits; outputs are looked at on the falling edge where they are settled.
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic look;
    @(negedge pclk);
  endtask

  // APB transfer: setup, access held until pready is sampled high, then release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls the state field until it matches or the poll budget runs out.
  task automatic wait_st(input logic [3:0] s, input int mx);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      k++;
    end while (q[3:0] !== s && k < mx);
    chk("state", {28'h0, s}, {28'h0, q[3:0]});
  endtask

  // Reset values, register map and refusals.
  task automatic t_regs;
    look;
    chk("hi_z", 4'hf, bridge.hi_z);
    chk("fault_n", 1, fault_n);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h00640101, q);
    apb(1'b1, 8'h08, 32'h0000ffff);
    chk("pslverr", 1, e);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped", 0, q);
    apb(1'b1, 8'h04, 32'h0000000f);
    wait_st(4'h0, 1);
    $display("test regs done");
  endtask

  // First power-up: check length, fault held low, bridges Hi-Z with pulldowns, then idle.
  task automatic t_check;
    int k;
    int n;
    @(posedge pclk);
    pn.gate_drive_ok    <= 1'b1;
    pn.logic_ok         <= 1'b1;
    pn.output_supply_ok <= 1'b1;
    k = 0;
    while (fault_n !== 1'b0 && k < 20) begin
      look;
      k++;
    end
    n = 0;
    while (fault_n === 1'b0 && n < 300) begin
      look;
      n++;
    end
    chk("check_len", 1, n >= 54 && n <= 64);
    chk("pulldown", 4'hf, bridge.pulldown_en);
    chk("hi_z", 4'hf, bridge.hi_z);
    wait_st(4'h3, 5);
    $display("test check done");
  endtask

  // Check re-armed by logic supply drop; a supply short holds it while reset toggles.
  task automatic t_short;
    @(posedge pclk);
    pn.logic_ok <= 1'b0;
    cy(8);
    pn.short_sup <= 4'h4;
    pn.logic_ok  <= 1'b1;
    cy(20);
    pn.amp_reset_n <= 1'b1;
    cy(100);
    look;
    chk("fault_n", 0, fault_n);
    chk("hi_z", 4'hf, bridge.hi_z);
    wait_st(4'h2, 1);
    @(posedge pclk);
    pn.short_sup   <= 4'h0;
    pn.amp_reset_n <= 1'b0;
    wait_st(4'h3, 40);
    $display("test short done");
  endtask

  // Ramp up with the reset ramp capacitor: 200 ms is 800 cycles.
  task automatic t_ramp;
    logic [3:0] g;
    @(posedge pclk);
    pn.amp_reset_n <= 1'b1;
    wait_st(4'h4, 10);
    look;
    g = bridge.pwm_out;
    look;
    chk("pwm_out", g ^ 4'hf, bridge.pwm_out);
    cy(760);
    look;
    chk("ramp_ms", 1, ramp_ms >= 17'h000b9 && ramp_ms < 17'h000c8);
    wait_st(4'h4, 1);
    wait_st(4'h5, 40);
    look;
    chk("hi_z", 0, bridge.hi_z);
    $display("test ramp done");
  endtask

  // Bootstrap undervoltage drops one high side; overload latches its group.
  task automatic t_chan;
    @(posedge pclk);
    pn.bootstrap_uv <= 4'h2;
    cy(5);
    look;
    chk("high_side", 4'hd, bridge.high_side_en);
    chk("hi_z", 0, bridge.hi_z);
    @(posedge pclk);
    pn.bootstrap_uv <= 4'h0;
    pn.overload     <= 4'h1;
    cy(5);
    look;
    chk("hi_z", 4'h3, bridge.hi_z);
    chk("fault_n", 0, fault_n);
    @(posedge pclk);
    pn.overload <= 4'h0;
    cy(10);
    look;
    chk("hi_z", 4'h3, bridge.hi_z);
    @(posedge pclk);
    pn.amp_reset_n <= 1'b0;
    cy(5);
    look;
    chk("fault_n", 1, fault_n);
    wait_st(4'h3, 300);
    $display("test chan done");
  endtask

  // Parallel mode, no ramp capacitor: 100 ms ramp; any overload shuts all four.
  task automatic t_parallel;
    apb(1'b1, 8'h00, 32'h00000103);
    @(posedge pclk);
    pn.amp_reset_n <= 1'b1;
    wait_st(4'h4, 10);
    cy(370);
    wait_st(4'h4, 1);
    wait_st(4'h5, 30);
    @(posedge pclk);
    pn.overload <= 4'h4;
    cy(5);
    look;
    chk("hi_z", 4'hf, bridge.hi_z);
    @(posedge pclk);
    pn.overload    <= 4'h0;
    pn.amp_reset_n <= 1'b0;
    cy(8);
    pn.amp_reset_n <= 1'b1;
    wait_st(4'h5, 300);
    $display("test parallel done");
  endtask

  // Thermal warning, then latched shutdown cleared only by reset.
  task automatic t_thermal;
    @(posedge pclk);
    pn.temp_hot <= 1'b1;
    cy(5);
    look;
    chk("warn_n", 0, temp_warn_n);
    chk("fault_n", 1, fault_n);
    @(posedge pclk);
    pn.temp_trip <= 1'b1;
    cy(5);
    look;
    chk("hi_z", 4'hf, bridge.hi_z);
    chk("fault_n", 0, fault_n);
    @(posedge pclk);
    pn.temp_trip <= 1'b0;
    pn.temp_hot  <= 1'b0;
    cy(10);
    look;
    chk("fault_n", 0, fault_n);
    chk("warn_n", 1, temp_warn_n);
    @(posedge pclk);
    pn.amp_reset_n <= 1'b0;
    cy(5);
    look;
    chk("fault_n", 1, fault_n);
    wait_st(4'h3, 5);
    chk("trip_latch", 0, q[5]);
    $display("test thermal done");
  endtask

  // Supply undervoltage recovers by itself; single-ended mode skips the check.
  task automatic t_uv;
    @(posedge pclk);
    pn.gate_drive_ok <= 1'b0;
    cy(5);
    look;
    chk("hi_z", 4'hf, bridge.hi_z);
    wait_st(4'h0, 1);
    @(posedge pclk);
    pn.gate_drive_ok <= 1'b1;
    wait_st(4'h3, 5);
    chk("done", 1, q[4]);
    apb(1'b1, 8'h00, 32'h00000105);
    @(posedge pclk);
    pn.logic_ok <= 1'b0;
    cy(8);
    pn.logic_ok <= 1'b1;
    cy(8);
    look;
    chk("fault_n", 1, fault_n);
    wait_st(4'h3, 1);
    $display("test uv done");
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_check();
    t_short();
    t_ramp();
    t_chan();
    t_parallel();
    t_thermal();
    t_uv();
    end_of_test();
  end
endmodule // classd_protection_sequencer_test
